// ### src/iegate_axil_slave.sv
// axi4-lite slave: single register at the enable offset
`timescale 1ns/100ps
`default_nettype none
module iegate_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] enables
);
  // ****************************************************************
  // write channel
  // ****************************************************************
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic [7:0] enables_reg;
  logic do_write;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata[7:0];
      wstrb0_reg <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // reserved bit 6 is never stored, so it cannot be set by a write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enables_reg <= iegate_pkg::IEGATE_ENABLES_RESET;
    end else if (do_write && wstrb0_reg
                 && awaddr_reg == iegate_pkg::IEGATE_ENABLES_OFFSET) begin
      enables_reg <= wdata_reg & iegate_pkg::IEGATE_WRITE_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= iegate_pkg::IEGATE_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_reg == iegate_pkg::IEGATE_ENABLES_OFFSET) begin
        s_axi_bresp <= iegate_pkg::IEGATE_RESP_OKAY;
      end else begin
        s_axi_bresp <= iegate_pkg::IEGATE_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  iegate_pkg::iegate_read_type read_next;

  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    read_next.data = 32'h0000_0000;
    read_next.resp = iegate_pkg::IEGATE_RESP_SLVERR;
    if (s_axi_araddr == iegate_pkg::IEGATE_ENABLES_OFFSET) begin
      read_next.data = {24'h00_0000, enables_reg | iegate_pkg::IEGATE_RESERVED_MASK};
      read_next.resp = iegate_pkg::IEGATE_RESP_OKAY;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= iegate_pkg::IEGATE_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_next.data;
      s_axi_rresp <= read_next.resp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign enables = enables_reg;
endmodule
`default_nettype wire

// ### src/iegate_pkg.sv
// package of constants and types for the interrupt source enable gating block
package iegate_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] IEGATE_ENABLES_OFFSET = 8'hA8;
  localparam logic [7:0] IEGATE_ENABLES_RESET = 8'h00;
  localparam logic [7:0] IEGATE_RESERVED_MASK = 8'h40;
  localparam logic [7:0] IEGATE_WRITE_MASK = 8'hBF;
  localparam int IEGATE_GLOBAL_BIT = 7;
  localparam int IEGATE_EXT0_BIT = 0;
  localparam int IEGATE_TIMER0_BIT = 1;
  localparam int IEGATE_EXT1_BIT = 2;
  localparam int IEGATE_TIMER1_BIT = 3;
  localparam int IEGATE_SERIAL_BIT = 4;
  localparam int IEGATE_TIMER2_BIT = 5;
  localparam int IEGATE_SOURCES = 6;
  localparam logic [1:0] IEGATE_RESP_OKAY = 2'h0;
  localparam logic [1:0] IEGATE_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic global_irq_enable;
    logic reserved;
    logic timer2_irq_enable;
    logic serial_irq_enable;
    logic timer1_irq_enable;
    logic ext_irq1_enable;
    logic timer0_irq_enable;
    logic ext_irq0_enable;
  } iegate_enables_type;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } iegate_read_type;

  typedef enum logic [1:0] {
    IEGATE_W_IDLE = 2'b00,
    IEGATE_W_RESP = 2'b01
  } iegate_wstate_type;
endpackage

// ### src/iegate_gate_bit.sv
// one source gate: pending request passed only when both enables are set
`timescale 1ns/100ps
`default_nettype none
module iegate_gate_bit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic global_en,
  input wire logic source_en,
  input wire logic request,
  output logic gated
);
  // registered so the gated output is a flip-flop, one cycle behind the request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gated <= 1'b0;
    end else begin
      gated <= global_en & source_en & request;
    end
  end
endmodule
`default_nettype wire

// ### src/iegate_top.sv
// top of the interrupt source enable gating block
`timescale 1ns/100ps
`default_nettype none
module iegate_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] irq_pending,
  output logic [5:0] irq_gated
);
  // ****************************************************************
  // register slave
  // ****************************************************************
  iegate_pkg::iegate_enables_type enables;

  iegate_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .enables(enables)
  );

  // ****************************************************************
  // gating, one gate per source; index equals bit position
  // ****************************************************************
  logic [5:0] source_en;

  // bit 0 ext0, bit 2 ext1 timers at 1,3,5, serial at 4
  assign source_en = {enables.timer2_irq_enable, enables.serial_irq_enable,
                      enables.timer1_irq_enable, enables.ext_irq1_enable,
                      enables.timer0_irq_enable, enables.ext_irq0_enable};

  genvar g;
  generate
    for (g = 0; g < iegate_pkg::IEGATE_SOURCES; g++) begin : gen_gate
      iegate_gate_bit u_gate (
        .aclk(aclk),
        .aresetn(aresetn),
        .global_en(enables.global_irq_enable),
        .source_en(source_en[g]),
        .request(irq_pending[g]),
        .gated(irq_gated[g])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// ### tb/iegate_chk.sv
// concurrent checks on the ports of the enable gating top
`timescale 1ns/100ps
`default_nettype none
module iegate_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] irq_pending,
  input wire logic [5:0] irq_gated
);
  // ****************************************************************
  // shadow of the enables, one cycle behind the design's copy
  // ****************************************************************
  logic [7:0] a_q, d_q, sh;
  logic s_q, b_q;
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) a_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) d_q <= s_axi_wdata[7:0];
    if (s_axi_wvalid && s_axi_wready) s_q <= s_axi_wstrb[0];
    b_q <= aresetn & s_axi_bvalid;
    if (!aresetn) sh <= 8'h00;
    else if (s_axi_bvalid && !b_q && a_q == iegate_pkg::IEGATE_ENABLES_OFFSET && s_q)
      sh <= d_q & iegate_pkg::IEGATE_WRITE_MASK;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rsvd_one_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h0 |-> s_axi_rdata[6])
    else $error("reserved bit read as zero");
  gate_off_a: assert property (!sh[7] |-> irq_gated == 6'h00)
    else $error("request passed with global enable off");
  ext_gate_a: assert property (|(irq_gated & 6'h05)
      |-> (irq_gated & 6'h05 & ~sh[5:0]) == 6'h00)
    else $error("external source passed while masked");
  src_mask_a: assert property (|irq_gated |-> (irq_gated & ~sh[5:0]) == 6'h00)
    else $error("source passed while masked");
  gate_pass_a: assert property (irq_gated == ($past(irq_pending) & sh[5:0] & {6{sh[7]}}))
    else $error("gated output differs from enabled requests");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_err_a: assert property ($rose(s_axi_bvalid) && a_q != 8'hA8 |-> s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (|irq_gated);
endmodule
bind iegate_top iegate_chk u_iegate_chk (.*);
`default_nettype wire

// ### tb/test_iegate_top.sv
// self-checking bench for the interrupt source enable gating block
`timescale 1ns/100ps
`default_nettype none
module test_iegate_top;
  // ****************************************************************
  // stimulus and checking
  // ****************************************************************
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, v;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'hC009, e;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] irq_pending = 6'h00, irq_gated;
  int error_cnt = 0, checks = 0;
  localparam logic [7:0] CORNER [8] = '{8'h00, 8'hFF, 8'h7F, 8'h80, 8'hBF, 8'h81, 8'hA0, 8'h84};
  iegate_top u_iegate_top (.*);
  always #2.5 aclk = ~aclk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [5:0] gate(input logic [5:0] p, input logic [7:0] en);
    return p & en[5:0] & {6{en[7]}};
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] g, input logic [1:0] x);
    checks++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic cmp_irq(input logic [5:0] g, input logic [5:0] x);
    checks++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // response held back one cycle so the slave must stand its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw, w, bk;
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      bk = s_axi_bvalid & s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) s_axi_bready <= 1'h1;
    end while (!bk);
    s_axi_bready <= 1'h0;
    cmp_resp(r, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, rk;
    logic [31:0] d;
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(negedge aclk);
      ar = s_axi_arvalid & s_axi_arready;
      rk = s_axi_rvalid & s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) s_axi_rready <= 1'h1;
    end while (!rk);
    s_axi_rready <= 1'h0;
    cmp(d, ed);
    cmp_resp(r, er);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(8'hA8, 32'h40, 2'h0);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      v = (i < 8) ? CORNER[i] : seed[7:0];
      wr(8'hA8, {seed[31:8], v}, 4'hF, 2'h0);
      irq_pending <= (i < 8) ? 6'h3F : seed[29:24];
      e = {24'h0, (v & 8'hBF) | 8'h40};
      rd(8'hA8, e, 2'h0);
      @(negedge aclk);
      cmp_irq(irq_gated, gate(irq_pending, v));
      @(posedge aclk);
    end
    $display("test gating done");
    wr(8'hA4, 32'hFF, 4'hF, 2'h2);
    rd(8'hA4, 32'h0, 2'h2);
    wr(8'hA8, 32'h00, 4'h0, 2'h0);
    rd(8'hA8, e, 2'h0);
    $display("test refusals done");
    // ****************************************************************
    // mid-run reset with all sources enabled and pending
    // ****************************************************************
    wr(8'hA8, 32'hFF, 4'hF, 2'h0);
    irq_pending <= 6'h3F;
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    @(negedge aclk);
    cmp_irq(irq_gated, 6'h00);
    @(posedge aclk);
    rd(8'hA8, 32'h40, 2'h0);
    $display("test reset done");
    end_of_test;
  end
endmodule
`default_nettype wire
